// ==== src/twm_pkg.sv ====
// constants, register map and state type of the two-wire master transmitter
package twm_pkg;
	// register byte addresses on the apb
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	// two_wire_control bit positions
	localparam int B_FLAG = 7;
	localparam int B_ACK_EN = 6;
	localparam int B_START = 5;
	localparam int B_STOP = 4;
	localparam int B_WCOL = 3;
	localparam int B_EN = 2;
	localparam int B_IE = 0;
	// prescaler field of the status register
	localparam int B_PRESC_HI = 1;
	// status codes, low three bits always zero
	localparam logic [7:0] ST_CODE_START = 8'h08;
	localparam logic [7:0] ST_CODE_RSTART = 8'h10;
	localparam logic [7:0] ST_CODE_AW_ACK = 8'h18;
	localparam logic [7:0] ST_CODE_AW_NACK = 8'h20;
	localparam logic [7:0] ST_CODE_D_ACK = 8'h28;
	localparam logic [7:0] ST_CODE_D_NACK = 8'h30;
	localparam logic [7:0] ST_CODE_LOST = 8'h38;
	localparam logic [7:0] ST_CODE_AR_ACK = 8'h40;
	localparam logic [7:0] ST_CODE_AR_NACK = 8'h48;
	localparam logic [7:0] ST_CODE_IDLE = 8'hf8;
	localparam logic [7:0] CODE_MASK = 8'hf8;
	// reset values
	localparam logic [7:0] RST_DATA = 8'hff;
	localparam logic [1:0] RST_PRESC = 2'h0;
	// bit timing: one scl period is four quarters
	localparam int T_QTR_NS = 2500;
	localparam int CLK_NS = 4;
	localparam int Q_CYC = (T_QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [9:0] Q_LOAD = 10'(Q_CYC - 1);
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [1:0] PH_LAST = 2'h3;
	// engine states
	typedef enum logic [2:0] {
		S_IDLE, S_WAIT, S_START, S_BIT, S_HOLD, S_STOP
	} twm_state_t;
endpackage

// ==== src/twm_sync.sv ====
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module twm_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// idle bus lines are high, so reset to one
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule // twm_sync
`default_nettype wire

// ==== src/twm_master_tx.sv ====
// two-wire master transmitter with apb registers
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module twm_master_tx (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// two-wire bus pins, open drain
	input wire logic i_scl,
	output logic o_scl_o,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	// interrupt request
	output logic o_irq
);
	logic [1:0] pins_s;
	logic scl_s, sda_s, scl_p_q, sda_p_q, busy_q, bus_free;
	logic flag_q, ea_q, sta_q, sto_q, wc_q, en_q, ie_q;
	logic [7:0] data_q, code_q, evt_code_q, shift_q;
	logic [1:0] presc_q;
	logic [31:0] prdata_q;
	logic pslverr_q, wr_en, wr_ctrl, wr_stat, wr_data, hit;
	twm_pkg::twm_state_t st_q;
	logic [9:0] cnt_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic tick, evt_q, idle_evt_q, sto_clr_q;
	logic scl_oe_q, sda_oe_q, lost_q, mr_q, addr_q, ack_q, master_q;
	logic lose_now;

	// bus pins pass two flops before use
	twm_sync #(.W(2)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async({i_scl, i_sda}),
		.o_sync(pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// busy from start/stop seen on the bus, ours or another master's
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			if (scl_s && scl_p_q && sda_p_q && !sda_s) begin
				busy_q <= 1'b1;
			end else if (scl_s && scl_p_q && !sda_p_q && sda_s) begin
				busy_q <= 1'b0;
			end
		end
	end
	assign bus_free = !busy_q && scl_s && sda_s;

	// apb decode; no wait states, read data comes from a flop loaded in the setup cycle
	assign hit = (i_paddr == twm_pkg::OFF_CTRL) ||
		(i_paddr == twm_pkg::OFF_STAT) || (i_paddr == twm_pkg::OFF_DATA);
	assign o_pready = i_psel && i_penable;
	assign o_pslverr = o_pready && pslverr_q;
	assign o_prdata = prdata_q;
	assign wr_en = o_pready && i_pwrite && !pslverr_q;
	assign wr_ctrl = wr_en && (i_paddr == twm_pkg::OFF_CTRL);
	assign wr_stat = wr_en && (i_paddr == twm_pkg::OFF_STAT);
	assign wr_data = wr_en && (i_paddr == twm_pkg::OFF_DATA);

	// read mux captured in the setup cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (i_psel && !i_penable) begin
			pslverr_q <= !hit;
			case (i_paddr)
				twm_pkg::OFF_CTRL: begin
					prdata_q <= {24'h00_0000, flag_q, ea_q, sta_q, sto_q,
						wc_q, en_q, 1'b0, ie_q};
				end
				twm_pkg::OFF_STAT: begin
					prdata_q <= {24'h00_0000, code_q[7:3], 1'b0, presc_q};
				end
				twm_pkg::OFF_DATA: begin
					prdata_q <= {24'h00_0000, data_q};
				end
				default: begin
					prdata_q <= 32'h0000_0000;
				end
			endcase
		end
	end

	// control register; hardware set and clear win over software
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			flag_q <= 1'b0;
			ea_q <= 1'b0;
			sta_q <= 1'b0;
			sto_q <= 1'b0;
			en_q <= 1'b0;
			ie_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ea_q <= i_pwdata[twm_pkg::B_ACK_EN];
				sta_q <= i_pwdata[twm_pkg::B_START];
				sto_q <= i_pwdata[twm_pkg::B_STOP];
				en_q <= i_pwdata[twm_pkg::B_EN];
				ie_q <= i_pwdata[twm_pkg::B_IE];
				if (i_pwdata[twm_pkg::B_FLAG]) begin
					flag_q <= 1'b0;
				end
			end
			if (sto_clr_q) begin
				sto_q <= 1'b0;
			end
			if (evt_q) begin
				flag_q <= 1'b1;
			end
		end
	end

	// data register; writes while the flag is low are dropped
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			data_q <= twm_pkg::RST_DATA;
			wc_q <= 1'b0;
		end else if (wr_data) begin
			if (flag_q) begin
				data_q <= i_pwdata[7:0];
				wc_q <= 1'b0;
			end else begin
				wc_q <= 1'b1;
			end
		end
	end

	// status code and prescaler bits
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			code_q <= twm_pkg::ST_CODE_IDLE;
			presc_q <= twm_pkg::RST_PRESC;
		end else begin
			if (wr_stat) begin
				presc_q <= i_pwdata[twm_pkg::B_PRESC_HI:0];
			end
			if (evt_q) begin
				code_q <= evt_code_q & twm_pkg::CODE_MASK;
			end else if (idle_evt_q) begin
				code_q <= twm_pkg::ST_CODE_IDLE;
			end
		end
	end

	assign o_irq = flag_q && ie_q;

	// quarter-bit timer for active bus states
	assign tick = (cnt_q == 10'h000);
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || tick) begin
			cnt_q <= twm_pkg::Q_LOAD;
		end else if (st_q == twm_pkg::S_START || st_q == twm_pkg::S_BIT ||
			st_q == twm_pkg::S_STOP) begin
			cnt_q <= cnt_q - 10'h001;
		end else begin
			cnt_q <= twm_pkg::Q_LOAD;
		end
	end

	// another master pulled sda low while we released it
	assign lose_now = (st_q == twm_pkg::S_BIT) && tick &&
		(ph_q == 2'h2) && (bit_q != twm_pkg::ACK_BIT) &&
		shift_q[7] && !sda_s;

	// bus engine; no clock stretching, scl pace is fixed
	always_ff @(posedge i_clk_sys) begin
		evt_q <= 1'b0;
		idle_evt_q <= 1'b0;
		sto_clr_q <= 1'b0;
		if (!i_rst_n || !en_q) begin
			st_q <= twm_pkg::S_IDLE;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			evt_code_q <= twm_pkg::ST_CODE_IDLE;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			lost_q <= 1'b0;
			mr_q <= 1'b0;
			addr_q <= 1'b0;
			ack_q <= 1'b0;
			master_q <= 1'b0;
		end else begin
			if (tick) begin
				ph_q <= ph_q + 2'h1;
			end
			case (st_q)
				twm_pkg::S_IDLE: begin
					ph_q <= 2'h0;
					if (sta_q && !flag_q) begin
						st_q <= twm_pkg::S_WAIT;
					end
				end
				twm_pkg::S_WAIT: begin
					ph_q <= 2'h0;
					if (bus_free) begin
						st_q <= twm_pkg::S_START;
					end
				end
				twm_pkg::S_START: begin
					if (tick) begin
						case (ph_q)
							2'h0: sda_oe_q <= 1'b0;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b1;
							default: begin
								scl_oe_q <= 1'b1;
								st_q <= twm_pkg::S_HOLD;
								evt_q <= 1'b1;
								evt_code_q <= master_q ? twm_pkg::ST_CODE_RSTART :
									twm_pkg::ST_CODE_START;
								master_q <= 1'b1;
								addr_q <= 1'b1;
							end
						endcase
					end
				end
				twm_pkg::S_BIT: begin
					if (lose_now) begin
						scl_oe_q <= 1'b0;
						sda_oe_q <= 1'b0;
						lost_q <= 1'b1;
						master_q <= 1'b0;
						st_q <= twm_pkg::S_HOLD;
						evt_q <= 1'b1;
						evt_code_q <= twm_pkg::ST_CODE_LOST;
					end else if (tick) begin
						case (ph_q)
							2'h0: sda_oe_q <= (bit_q == twm_pkg::ACK_BIT) ?
								1'b0 : !shift_q[7];
							2'h1: scl_oe_q <= 1'b0;
							2'h2: ack_q <= !sda_s;
							default: begin
								scl_oe_q <= 1'b1;
								if (bit_q == twm_pkg::ACK_BIT) begin
									st_q <= twm_pkg::S_HOLD;
									evt_q <= 1'b1;
									addr_q <= 1'b0;
									if (addr_q && mr_q) begin
										evt_code_q <= ack_q ? twm_pkg::ST_CODE_AR_ACK :
											twm_pkg::ST_CODE_AR_NACK;
									end else if (addr_q) begin
										evt_code_q <= ack_q ? twm_pkg::ST_CODE_AW_ACK :
											twm_pkg::ST_CODE_AW_NACK;
									end else begin
										evt_code_q <= ack_q ? twm_pkg::ST_CODE_D_ACK :
											twm_pkg::ST_CODE_D_NACK;
									end
								end else begin
									bit_q <= bit_q + 4'h1;
									shift_q <= {shift_q[6:0], 1'b1};
								end
							end
						endcase
					end
				end
				twm_pkg::S_HOLD: begin
					ph_q <= 2'h0;
					bit_q <= 4'h0;
					// act only once the flag is really cleared
					if (!flag_q && !evt_q) begin
						if (lost_q) begin
							lost_q <= 1'b0;
							if (sta_q) begin
								st_q <= twm_pkg::S_WAIT;
							end else begin
								st_q <= twm_pkg::S_IDLE;
								idle_evt_q <= 1'b1;
							end
						end else if (sto_q) begin
							st_q <= twm_pkg::S_STOP;
						end else if (sta_q) begin
							st_q <= twm_pkg::S_START;
						end else if (addr_q || !mr_q) begin
							st_q <= twm_pkg::S_BIT;
							shift_q <= data_q;
							if (addr_q) begin
								mr_q <= data_q[0];
							end
						end
					end
				end
				twm_pkg::S_STOP: begin
					if (tick) begin
						case (ph_q)
							2'h0: sda_oe_q <= 1'b1;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b0;
							default: begin
								sto_clr_q <= 1'b1;
								master_q <= 1'b0;
								mr_q <= 1'b0;
								idle_evt_q <= 1'b1;
								st_q <= sta_q ? twm_pkg::S_WAIT :
									twm_pkg::S_IDLE;
							end
						endcase
					end
				end
				default: begin
					st_q <= twm_pkg::S_IDLE;
				end
			endcase
		end
	end

	// open-drain drive: only ever pull low
	assign o_scl_o = 1'b0;
	assign o_sda_o = 1'b0;
	assign o_scl_oe = scl_oe_q;
	assign o_sda_oe = sda_oe_q;

	// disabling the block may drop the bus at any time, so only while enabled
	a_hold_frozen: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(st_q == twm_pkg::S_HOLD && flag_q && en_q) |=>
		(st_q == twm_pkg::S_HOLD && $stable(o_scl_oe) && $stable(o_sda_oe)))
		else $error("bus moved while flag set");
	a_start_code: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(st_q == twm_pkg::S_START && tick && ph_q == 2'h3 && !master_q
		&& en_q) |-> ##2 (flag_q && code_q == 8'h08))
		else $error("start status not reported");
	a_rstart_code: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(st_q == twm_pkg::S_START && tick && ph_q == 2'h3 && master_q
		&& en_q) |-> ##2 (flag_q && code_q == 8'h10))
		else $error("repeated start status wrong");
	a_wcol_set: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(wr_data && !flag_q) |=> (wc_q && $stable(data_q)))
		else $error("collision write not refused");
	a_flag_clear: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(wr_ctrl && i_pwdata[7] && !evt_q) |=> !flag_q)
		else $error("flag not cleared by writing one");
	a_stop_clear: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(st_q == twm_pkg::S_STOP && tick && ph_q == 2'h3 && en_q && !wr_ctrl)
		|-> ##2 (!sto_q && !o_sda_oe && !o_scl_oe))
		else $error("stop request not cleared");
	a_lost_release: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(lose_now && en_q) |=> (!o_sda_oe && !o_scl_oe)
		##1 (flag_q && code_q == 8'h38))
		else $error("lost arbitration not handled");
	a_addr_code: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(st_q == twm_pkg::S_BIT && tick && ph_q == 2'h3 && en_q &&
		bit_q == 4'h8 && addr_q && !mr_q) |-> ##2
		(code_q == (ack_q ? 8'h18 : 8'h20)))
		else $error("address status wrong");
	a_wait_start: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(st_q == twm_pkg::S_WAIT && bus_free && en_q) |=>
		(st_q == twm_pkg::S_START) [*4])
		else $error("start not issued on free bus");
	a_irq_rise: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		($rose(flag_q) && ie_q) |-> o_irq)
		else $error("interrupt not raised");
	// only status reads; control reads carry the enable bit in that place
	a_code_mask: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_pready && !i_pwrite && i_paddr == twm_pkg::OFF_STAT) |->
		(o_prdata[7:3] == $past(code_q[7:3]) && o_prdata[2] == 1'b0))
		else $error("status low bits not masked");
endmodule // twm_master_tx
`default_nettype wire

// ==== tb/twm_slave_model.sv ====
// behavioural slave receiver on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module twm_slave_model (
	// bus wire levels
	input wire logic i_scl,
	input wire logic i_sda,
	// answer with ack when high
	input wire logic i_ack_on,
	// pulls sda low when high
	output logic o_sda_oe,
	// what the slave saw
	output logic [7:0] o_byte,
	output var int o_starts,
	output var int o_stops
);
	logic [7:0] sh;
	logic [3:0] bit_n;
	logic active;
	logic ack_ph;
	// idle: line released, nothing seen
	initial begin
		o_sda_oe = 1'b0;
		o_byte = 8'h00;
		o_starts = 0;
		o_stops = 0;
		active = 1'b0;
		ack_ph = 1'b0;
		bit_n = 4'h0;
		sh = 8'h00;
	end
	// start: sda falls with scl high
	always @(negedge i_sda) begin
		if (i_scl === 1'b1) begin
			active = 1'b1;
			bit_n = 4'h0;
			ack_ph = 1'b0;
			o_starts++;
		end
	end
	// stop only counts inside a frame, so power-up edges are ignored
	always @(posedge i_sda) begin
		if (i_scl === 1'b1 && active) begin
			active = 1'b0;
			o_stops++;
		end
	end
	// msb first, sampled on scl rise
	always @(posedge i_scl) begin
		if (active && !ack_ph && bit_n < 4'h8) begin
			sh = {sh[6:0], i_sda};
			bit_n++;
		end
	end
	// ack slot driven between two scl falls
	always @(negedge i_scl) begin
		if (active && ack_ph) begin
			ack_ph = 1'b0;
			o_sda_oe = 1'b0;
			bit_n = 4'h0;
		end else if (active && bit_n == 4'h8) begin
			ack_ph = 1'b1;
			o_sda_oe = i_ack_on;
			o_byte = sh;
		end
	end
endmodule // twm_slave_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the two-wire master transmitter
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, irq;
	logic scl_o, scl_oe, sda_o, sda_oe, slv_oe, scl_w, sda_w, ack_on;
	logic cm_oe;
	logic [7:0] paddr, slv_byte, adr, dat;
	logic [31:0] pwdata, prdata, rd;
	int slv_starts, slv_stops, n_mismatch, check_count;
	// open drain wires with pull-ups
	assign scl_w = scl_oe ? scl_o : 1'b1;
	// cm_oe stands for a competing master pulling sda
	assign sda_w = (sda_oe ? sda_o : 1'b1) & ~slv_oe & ~cm_oe;
	twm_master_tx i_twm_master_tx (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_scl(scl_w),
		.o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_w),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_irq(irq));
	twm_slave_model i_twm_slave_model (.i_scl(scl_w), .i_sda(sda_w),
		.i_ack_on(ack_on), .o_sda_oe(slv_oe), .o_byte(slv_byte),
		.o_starts(slv_starts), .o_stops(slv_stops));
	// 250 mhz system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer; leading edge keeps back-to-back calls apart
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// a byte takes 36 quarters, so the poll bound is generous
	task automatic wait_reg(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((rd[7:0] & m) !== v && n < 12000);
		if (n >= 12000) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	task automatic wait_flag();
		wait_reg(twm_pkg::OFF_CTRL, 8'h80, 8'h80);
	endtask
	task automatic expect_status(input logic [7:0] code);
		apb(1'b0, twm_pkg::OFF_STAT, 32'h0);
		check("status", rd, 32'(code & twm_pkg::CODE_MASK));
	endtask
	// software sends addresses with the write bit low
	function automatic logic [7:0] addr_w(input logic [6:0] a);
		return {a, 1'b0};
	endfunction
	// main sequence; every control write keeps enable set
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
		cm_oe = 1'b0;
		ack_on = 1'b1;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		void'($urandom(48));
		apb(1'b0, twm_pkg::OFF_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h00);
		expect_status(8'hf8);
		apb(1'b0, twm_pkg::OFF_DATA, 32'h0);
		check("data reset", rd, 32'hff);
		apb(1'b0, 8'h0c, 32'h0);
		check("unmapped err", 32'(err), 32'h1);
		apb(1'b1, twm_pkg::OFF_STAT, 32'h3);
		apb(1'b0, twm_pkg::OFF_STAT, 32'h0);
		check("prescaler", rd, 32'hfb);
		check("masked code", rd & 32'hf8, 32'hf8);
		apb(1'b1, twm_pkg::OFF_STAT, 32'h0);
		$display("test registers done");
		apb(1'b1, twm_pkg::OFF_DATA, 32'h5a);
		apb(1'b0, twm_pkg::OFF_DATA, 32'h0);
		check("data kept", rd, 32'hff);
		apb(1'b0, twm_pkg::OFF_CTRL, 32'h0);
		check("collision", rd, 32'h08);
		$display("test collision done");
		apb(1'b1, twm_pkg::OFF_CTRL, 32'ha5);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_START);
		check("irq set", 32'(irq), 32'h1);
		check("starts", 32'(slv_starts), 32'h1);
		apb(1'b1, twm_pkg::OFF_CTRL, 32'h05);
		repeat (3000) @(posedge clk);
		expect_status(twm_pkg::ST_CODE_START);
		check("scl held", 32'(scl_oe), 32'h1);
		$display("test start done");
		adr = addr_w(7'($urandom));
		apb(1'b1, twm_pkg::OFF_DATA, 32'(adr));
		apb(1'b0, twm_pkg::OFF_CTRL, 32'h0);
		check("collision off", 32'(rd[3]), 32'h0);
		apb(1'b1, twm_pkg::OFF_CTRL, 32'h85);
		@(negedge clk);
		check("irq clear", 32'(irq), 32'h0);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_AW_ACK);
		check("address", 32'(slv_byte), 32'(adr));
		dat = 8'($urandom);
		apb(1'b1, twm_pkg::OFF_DATA, 32'(dat));
		apb(1'b1, twm_pkg::OFF_CTRL, 32'h85);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_D_ACK);
		check("data byte", 32'(slv_byte), 32'(dat));
		$display("test bytes done");
		apb(1'b1, twm_pkg::OFF_CTRL, 32'ha5);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_RSTART);
		check("restart", 32'(slv_starts), 32'h2);
		check("no stop", 32'(slv_stops), 32'h0);
		ack_on <= 1'b0;
		adr = addr_w(7'($urandom));
		apb(1'b1, twm_pkg::OFF_DATA, 32'(adr));
		apb(1'b1, twm_pkg::OFF_CTRL, 32'h85);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_AW_NACK);
		check("address 2", 32'(slv_byte), 32'(adr));
		$display("test restart done");
		ack_on <= 1'b1;
		apb(1'b1, twm_pkg::OFF_CTRL, 32'hb5);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_START);
		check("stop start", 32'(slv_stops), 32'h1);
		check("new start", 32'(slv_starts), 32'h3);
		apb(1'b0, twm_pkg::OFF_CTRL, 32'h0);
		check("stop bit", 32'(rd[4]), 32'h0);
		apb(1'b1, twm_pkg::OFF_CTRL, 32'h95);
		wait_reg(twm_pkg::OFF_STAT, 8'hff, twm_pkg::ST_CODE_IDLE);
		check("stop", 32'(slv_stops), 32'h2);
		apb(1'b0, twm_pkg::OFF_CTRL, 32'h0);
		check("stop bit", 32'(rd[4]), 32'h0);
		check("lines free", 32'({scl_oe, sda_oe}), 32'h0);
		$display("test stop done");
		// another master holds sda low under our first address bit
		apb(1'b1, twm_pkg::OFF_CTRL, 32'ha5);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_START);
		adr = addr_w(7'($urandom) | 7'h40);
		apb(1'b1, twm_pkg::OFF_DATA, 32'(adr));
		cm_oe <= 1'b1;
		apb(1'b1, twm_pkg::OFF_CTRL, 32'h85);
		wait_flag();
		expect_status(twm_pkg::ST_CODE_LOST);
		check("lost release", 32'({scl_oe, sda_oe}), 32'h0);
		cm_oe <= 1'b0;
		apb(1'b1, twm_pkg::OFF_CTRL, 32'h85);
		wait_reg(twm_pkg::OFF_STAT, 8'hff, twm_pkg::ST_CODE_IDLE);
		apb(1'b0, twm_pkg::OFF_CTRL, 32'h0);
		check("lost idle", rd, 32'h05);
		check("drive level", 32'({scl_o, sda_o}), 32'h0);
		$display("test lost done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
